// ### hw/glue_pkg.sv
/*
  Constants and state layout for the system support glue block.
  Assumes a single 50 MHz core clock and a synchronous active-high reset.
*/
package glue_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int BCLK_PERIOD_NS = 120;
  localparam int ALT_RST_BCLKS = 4;
  // Pulse time in ns, then rounded down to core cycles
  localparam int ALT_RST_NS = ALT_RST_BCLKS * BCLK_PERIOD_NS;
  localparam int ALT_RST_CYCLES = (ALT_RST_NS / CLK_PERIOD_NS < 1) ? 1 : ALT_RST_NS / CLK_PERIOD_NS;
  localparam logic [4:0] ALT_RST_CNT = 5'(ALT_RST_CYCLES);

  // ----------------------------------------
  // I/O ports and decode values
  // ----------------------------------------
  localparam logic [15:0] NPX_CLR_PORT = 16'h00F0;
  localparam logic [15:0] KBD_DATA_PORT = 16'h0060;
  localparam logic [15:0] KBD_CMD_PORT = 16'h0064;
  localparam logic [15:0] SYS_CTRL_PORT = 16'h0092;
  localparam int ALT_RST_BIT = 0;
  localparam int ALT_A20_BIT = 1;
  // Boot ROM window: LA[23:17] match, E0000h..FFFFFh
  localparam logic [6:0] BIOS_LA_MATCH = 7'h07;

  // ----------------------------------------
  // Positions inside the synchronised pin vector
  // ----------------------------------------
  localparam int P_IOW = 0;
  localparam int P_IOR = 1;
  localparam int P_BALE = 2;
  localparam int P_REFRESH = 3;
  localparam int P_EISA = 4;
  localparam int P_CPU_NUMERIC_ERROR_N = 5;
  localparam int P_ABF = 6;
  localparam int P_CFG = 7;
  localparam int P_KGATE = 8;
  localparam int P_CPU_RESET_LINE = 9;
  localparam int P_ADDR = 10;
  localparam int P_DATA = 26;
  localparam int P_LA = 28;
  localparam int PIN_W = 35;
  // Idle pin levels: strobes, error and refresh are high when idle, so a
  // freshly reset synchroniser never shows a false strobe or error
  localparam logic [PIN_W-1:0] PIN_IDLE = 35'h0_0000_002b;

  typedef struct packed {
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic iow_prev;
    logic bios_hold;
    logic ign_n;
    logic irq13;
    logic rst_bit;
    logic [4:0] rst_cnt;
    logic rst_n;
    logic a20;
    logic mask_n;
    logic sale_n;
    logic la_sa_n;
    logic sa_la_n;
    logic bios_n;
    logic kbd_n;
    logic aux;
  } glue_state_s;

  // Value after reset: selects and LA-to-SA enable idle, SA-to-LA enable active,
  // fast reset and ignore-error outputs low as the pins require
  localparam glue_state_s ST_RST = '{
    s1: PIN_IDLE, s2: PIN_IDLE, iow_prev: 1'b0, bios_hold: 1'b0, ign_n: 1'b0,
    irq13: 1'b0, rst_bit: 1'b0, rst_cnt: 5'h00, rst_n: 1'b0, a20: 1'b0,
    mask_n: 1'b0, sale_n: 1'b1, la_sa_n: 1'b1, sa_la_n: 1'b0,
    bios_n: 1'b1, kbd_n: 1'b1, aux: 1'b0};
endpackage

// ### hw/system_support_glue.sv
/*
  System support glue: address buffer control, numeric error link,
  boot ROM and keyboard selects, port 92h fast reset and A20 gate.
  Assumes every pin input but srst_in is asynchronous to core_clk_in; all those pass two
  flip-flops. Outputs follow pins by three to four core cycles.
*/
// Contract
// - SA latch enable rises to capture LA[19:2]
// - LA-to-SA enable asserted in EISA cycles
// - SA-to-LA enable always opposite of LA-to-SA
// - Numeric error raises IRQ13 and CPU interrupt
// - Port F0h write asserts ignore, clears IRQ13
// - Ignore held until error negates; low in reset
// - Boot ROM select latched on BALE, refresh qualified
// - Keyboard select only for ports 60h, 64h
// - Port 92h bit0 write pulses fast reset
// - Bit0 must return zero before next pulse
// - Bit1 zero drives A20 gate low
// - Bit1 one forces A20 mask high
// - A20 gate low during system reset
// - Aux buffer full accepted when configured
`timescale 1ns/1ns
module system_support_glue
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  // I/O bus
  input wire logic io_write_n_in,
  input wire logic io_read_n_in,
  input wire logic [15:0] io_addr_in,
  input wire logic [1:0] io_data_in,
  // EISA address phase
  input wire logic bale_in,
  input wire logic refresh_n_in,
  input wire logic eisa_master_in,
  input wire logic [6:0] la_addr_hi_in,
  // CPU and keyboard controller
  input wire logic cpu_numeric_error_n_in,
  input wire logic aux_buffer_full_in,
  input wire logic clock_divisor_config_in,
  input wire logic kbc_addr20_gate_in,
  input wire logic cpu_reset_line_in,
  // Address buffer control
  output logic addr_latch_enable_n_out,
  output logic la_to_sa_buffer_oe_n_out,
  output logic sa_to_la_buffer_oe_n_out,
  // CPU side
  output logic ignore_numeric_error_n_out,
  output logic cpu_interrupt_request_out,
  output logic fast_cpu_reset_n_out,
  output logic alternate_addr20_gate_out,
  output logic cpu_addr20_mask_n_out,
  // Chip selects and mouse status
  output logic latched_boot_rom_select_n_out,
  output logic keyboard_ctrl_select_n_out,
  output logic aux_data_ready_out
);
  import glue_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic port_hit(input logic [15:0] addr, input logic [15:0] port);
    port_hit = (addr == port);
  endfunction

  glue_state_s st;
  glue_state_s st_nxt;
  logic iow_n;
  logic ior_n;
  logic bale;
  logic cpu_numeric_error_n_n;
  logic [15:0] addr;
  logic iow_fall;
  logic npx_wr;
  logic p92_wr;
  logic rst_start;

  // Decoded views of the second synchroniser stage only
  assign iow_n = st.s2[P_IOW];
  assign ior_n = st.s2[P_IOR];
  assign bale = st.s2[P_BALE];
  assign cpu_numeric_error_n_n = st.s2[P_CPU_NUMERIC_ERROR_N];
  assign addr = st.s2[P_ADDR +: 16];
  assign iow_fall = st.iow_prev & ~iow_n;
  assign npx_wr = iow_fall & port_hit(addr, NPX_CLR_PORT);
  assign p92_wr = iow_fall & port_hit(addr, SYS_CTRL_PORT);
  // New pulse only on a 0 to 1 step of the stored bit
  assign rst_start = p92_wr & st.s2[P_DATA + ALT_RST_BIT] & ~st.rst_bit;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    st_nxt = st;
    st_nxt.s1 = {la_addr_hi_in, io_data_in, io_addr_in, cpu_reset_line_in, kbc_addr20_gate_in,
                 clock_divisor_config_in, aux_buffer_full_in, cpu_numeric_error_n_in,
                 eisa_master_in, refresh_n_in, bale_in, io_read_n_in, io_write_n_in};
    st_nxt.s2 = st.s1;
    st_nxt.iow_prev = iow_n;
    // Latch low while BALE high, rising edge captures address
    st_nxt.sale_n = ~bale;
    st_nxt.la_sa_n = ~st.s2[P_EISA];
    st_nxt.sa_la_n = st.s2[P_EISA];
    // Error negation wins so ignore never sticks past the error
    if (cpu_numeric_error_n_n)
    begin
      st_nxt.ign_n = 1'b1;
    end
    else if (npx_wr)
    begin
      st_nxt.ign_n = 1'b0;
    end
    st_nxt.irq13 = ~cpu_numeric_error_n_n & st_nxt.ign_n;
    // Transparent while BALE high, closed after its fall
    if (bale)
    begin
      st_nxt.bios_hold = (st.s2[P_LA +: 7] == BIOS_LA_MATCH);
    end
    st_nxt.bios_n = ~(st.bios_hold & st.s2[P_REFRESH]);
    st_nxt.kbd_n = ~(~(iow_n & ior_n) & (port_hit(addr, KBD_DATA_PORT) | port_hit(addr, KBD_CMD_PORT)));
    if (p92_wr)
    begin
      st_nxt.a20 = st.s2[P_DATA + ALT_A20_BIT];
      st_nxt.rst_bit = st.s2[P_DATA + ALT_RST_BIT];
    end
    if (rst_start)
    begin
      st_nxt.rst_cnt = ALT_RST_CNT;
    end
    else if (st.rst_cnt != 5'h00)
    begin
      st_nxt.rst_cnt = st.rst_cnt - 5'h01;
    end
    st_nxt.rst_n = (st_nxt.rst_cnt == 5'h00);
    // External OR of both gates and CPU reset drives the mask
    st_nxt.mask_n = st_nxt.a20 | st.s2[P_KGATE] | st.s2[P_CPU_RESET_LINE];
    st_nxt.aux = st.s2[P_ABF] & st.s2[P_CFG];
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      st <= ST_RST;
    end
    else
    begin
      st <= st_nxt;
    end
  end

  // Every output straight from a flip-flop
  assign addr_latch_enable_n_out = st.sale_n;
  assign la_to_sa_buffer_oe_n_out = st.la_sa_n;
  assign sa_to_la_buffer_oe_n_out = st.sa_la_n;
  assign ignore_numeric_error_n_out = st.ign_n;
  assign cpu_interrupt_request_out = st.irq13;
  assign fast_cpu_reset_n_out = st.rst_n;
  assign alternate_addr20_gate_out = st.a20;
  assign cpu_addr20_mask_n_out = st.mask_n;
  assign latched_boot_rom_select_n_out = st.bios_n;
  assign keyboard_ctrl_select_n_out = st.kbd_n;
  assign aux_data_ready_out = st.aux;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  oe_opposite_a: assert property (st.la_sa_n != st.sa_la_n) else $error("buffer enables not opposite");
  oe_eisa_a: assert property (st.s2[P_EISA] |=> !la_to_sa_buffer_oe_n_out)
    else $error("LA-to-SA enable missing");
  sale_follow_a: assert property (bale |=> !addr_latch_enable_n_out ##1 1'b1)
    else $error("latch enable not low in BALE");
  cpu_interrupt_request_error_a: assert property ((!cpu_numeric_error_n_n && ignore_numeric_error_n_out && !npx_wr) |=> cpu_interrupt_request_out)
    else $error("interrupt not raised on error");
  ignore_set_a: assert property ((npx_wr && !cpu_numeric_error_n_n) |=> (!ignore_numeric_error_n_out && !cpu_interrupt_request_out))
    else $error("port F0 write not handled");
  ignore_release_a: assert property (cpu_numeric_error_n_n |=> ignore_numeric_error_n_out)
    else $error("ignore held after error negated");
  bios_hold_a: assert property (!bale |=> $stable(st.bios_hold))
    else $error("boot select latch moved while closed");
  kbd_decode_a: assert property (!keyboard_ctrl_select_n_out |-> ($past(addr) == KBD_DATA_PORT || $past(addr) == KBD_CMD_PORT))
    else $error("keyboard select on wrong port");
  rst_pulse_a: assert property (rst_start |=> !fast_cpu_reset_n_out ##23 !fast_cpu_reset_n_out ##1 fast_cpu_reset_n_out)
    else $error("fast reset pulse length wrong");
  rst_rearm_a: assert property ((p92_wr && st.rst_bit && st.rst_cnt == 5'h00) |=> fast_cpu_reset_n_out)
    else $error("pulse without rearm");
  a20_write_a: assert property (p92_wr |=> alternate_addr20_gate_out == $past(st.s2[P_DATA + ALT_A20_BIT]))
    else $error("A20 gate not written");
  a20_mask_a: assert property (alternate_addr20_gate_out |-> cpu_addr20_mask_n_out)
    else $error("A20 mask low with gate set");
  a20_hold_a: assert property (!p92_wr |=> $stable(alternate_addr20_gate_out))
    else $error("A20 gate changed without write");

  // Guards on refresh qualification, strobe gating, mask and aux enable
  bios_refresh_a: assert property (!st.s2[P_REFRESH] |=> latched_boot_rom_select_n_out)
    else $error("boot select active in refresh");
  kbd_strobe_a: assert property ((iow_n && ior_n) |=> keyboard_ctrl_select_n_out)
    else $error("keyboard select without strobe");
  a20_mask_low_a: assert property ((!st.s2[P_KGATE] && !st.s2[P_CPU_RESET_LINE] && !p92_wr && !alternate_addr20_gate_out)
    |=> !cpu_addr20_mask_n_out) else $error("A20 mask high with all gates low");
  cpu_interrupt_request_ignore_a: assert property (!ignore_numeric_error_n_out |-> !cpu_interrupt_request_out)
    else $error("interrupt raised while ignoring");
  aux_gate_a: assert property (!st.s2[P_CFG] |=> !aux_data_ready_out)
    else $error("aux ready while disabled");

  pulse_c: cover property (rst_start ##1 !fast_cpu_reset_n_out);
  npx_c: cover property (npx_wr && !cpu_numeric_error_n_n);
  kbd_c: cover property (!keyboard_ctrl_select_n_out);
  a20_c: cover property (p92_wr ##1 alternate_addr20_gate_out);
  // Latch closed on a matching address, select seen afterwards
  bios_c: cover property (bale ##1 !bale ##1 !latched_boot_rom_select_n_out);
endmodule

// ### dv/cpu_err_model.sv
/*
  Far side model: the CPU numeric error line.
  Assumes the bench pulses raise_in only after the block leaves reset.
*/
`timescale 1ns/1ns
module cpu_err_model
(
  // Clock and control
  input wire logic clk_in,
  input wire logic raise_in,
  input wire logic ignore_numeric_error_n_in,
  // Error line toward the block
  output logic cpu_numeric_error_n_out
);
  logic [5:0] hold_ff = 6'h00;
  logic err_n_ff = 1'b1;
  assign cpu_numeric_error_n_out = err_n_ff;
  // Slow handler: error drops long after ignore, so ignore can be seen held
  always_ff @(posedge clk_in)
  begin
    if (raise_in)
      err_n_ff <= 1'b0;
    else if (!err_n_ff && !ignore_numeric_error_n_in)
    begin
      hold_ff <= hold_ff + 6'h01;
      if (hold_ff == 6'h3F)
        err_n_ff <= 1'b1;
    end
  end
endmodule

// ### dv/testbench.sv
/*
  Self-checking bench for the system support glue block.
  Assumes glue_pkg and the error line model are compiled first.
*/
`timescale 1ns/1ns
module testbench;
  import glue_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic iow_n = 1'b1;
  logic ior_n = 1'b1;
  logic crst = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [1:0] data = 2'b00;
  logic bale = 1'b0, ref_n = 1'b1, eisa = 1'b0, raise = 1'b0, abf = 1'b0, cfg = 1'b0, kg = 1'b0;
  logic [6:0] la = 7'h00;
  logic err_n, sale_n, lasa_n, sala_n, ign_n, cpu_interrupt_request, frst_n, a20, mask_n, bios_n, kbd_n, aux;
  int miscompares = 0;
  int n_checks = 0;
  // Every pin driven by a scenario, read strobe and CPU reset included
  system_support_glue system_support_glue_i (.core_clk_in(clk), .srst_in(srst),
    .io_write_n_in(iow_n), .io_read_n_in(ior_n), .io_addr_in(addr), .io_data_in(data),
    .bale_in(bale), .refresh_n_in(ref_n), .eisa_master_in(eisa), .la_addr_hi_in(la),
    .cpu_numeric_error_n_in(err_n), .aux_buffer_full_in(abf), .clock_divisor_config_in(cfg),
    .kbc_addr20_gate_in(kg), .cpu_reset_line_in(crst), .addr_latch_enable_n_out(sale_n),
    .la_to_sa_buffer_oe_n_out(lasa_n), .sa_to_la_buffer_oe_n_out(sala_n),
    .ignore_numeric_error_n_out(ign_n), .cpu_interrupt_request_out(cpu_interrupt_request),
    .fast_cpu_reset_n_out(frst_n), .alternate_addr20_gate_out(a20), .cpu_addr20_mask_n_out(mask_n),
    .latched_boot_rom_select_n_out(bios_n), .keyboard_ctrl_select_n_out(kbd_n),
    .aux_data_ready_out(aux));
  cpu_err_model cpu_err_model_i (.clk_in(clk), .raise_in(raise),
    .ignore_numeric_error_n_in(ign_n), .cpu_numeric_error_n_out(err_n));
  initial
  begin
    forever #10 clk = ~clk;
  end
  // Checks run at the edge and see values settled by the previous edge
  task automatic chk(input string what, input logic [7:0] expv, input logic [7:0] got);
    n_checks++;
    if (got !== expv)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, expv, got);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Strobe low six cycles, high long enough to time a full reset pulse
  task automatic io_wr(input logic [15:0] a, input logic [1:0] d, input logic kexp, input logic [7:0] pexp);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    data <= d;
    iow_n <= 1'b0;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clk);
      if (frst_n === 1'b0)
        n++;
      if (i == 5)
        chk("kbd select", 8'(kexp), 8'(kbd_n));
      if (i == 5)
        iow_n <= 1'b1;
    end
    chk("reset pulse cycles", pexp, 8'(n));
  endtask
  // Read strobe alone must select the keyboard controller too
  task automatic kbd_rd(input logic [15:0] a, input logic kexp);
    @(posedge clk);
    addr <= a;
    ior_n <= 1'b0;
    wt(6);
    chk("kbd read select", 8'(kexp), 8'(kbd_n));
    @(posedge clk);
    ior_n <= 1'b1;
    wt(3);
  endtask
  // Mid-run reset must drop A20 gate, fast reset and ignore
  task automatic t_midrst();
    io_wr(SYS_CTRL_PORT, 2'b10, 1'b1, 8'h00);
    chk("a20 before reset", 8'h01, 8'(a20));
    @(posedge clk) srst <= 1'b1;
    wt(3);
    chk("a20 mid reset", 8'h00, 8'(a20));
    chk("fast reset mid reset", 8'h00, 8'(frst_n));
    chk("ignore mid reset", 8'h00, 8'(ign_n));
    @(posedge clk) srst <= 1'b0;
    wt(6);
    chk("a20 after reset", 8'h00, 8'(a20));
    chk("fast reset after reset", 8'h01, 8'(frst_n));
  endtask
  task automatic t_reset();
    chk("ignore in reset", 8'h00, 8'(ign_n));
    chk("fast reset in reset", 8'h00, 8'(frst_n));
    chk("a20 in reset", 8'h00, 8'(a20));
  endtask
  task automatic t_buffers();
    for (int m = 0; m < 2; m++)
    begin
      @(posedge clk);
      eisa <= ~m[0];
      wt(6);
      chk("la to sa oe", 8'(m[0]), 8'(lasa_n));
      chk("sa to la oe", {7'h00, ~m[0]}, 8'(sala_n));
    end
  endtask
  task automatic t_port92();
    io_wr(SYS_CTRL_PORT, 2'b11, 1'b1, 8'(ALT_RST_CYCLES));
    chk("a20 set", 8'h01, 8'(a20));
    chk("mask forced", 8'h01, 8'(mask_n));
    io_wr(SYS_CTRL_PORT, 2'b11, 1'b1, 8'h00);
    io_wr(SYS_CTRL_PORT, 2'b00, 1'b1, 8'h00);
    chk("a20 clear", 8'h00, 8'(a20));
    chk("mask low", 8'h00, 8'(mask_n));
    @(posedge clk) kg <= 1'b1;
    wt(6);
    chk("mask by kbc gate", 8'h01, 8'(mask_n));
    @(posedge clk) kg <= 1'b0;
    @(posedge clk) crst <= 1'b1;
    wt(6);
    chk("mask by cpu reset", 8'h01, 8'(mask_n));
    @(posedge clk) crst <= 1'b0;
    io_wr(SYS_CTRL_PORT, 2'b01, 1'b1, 8'(ALT_RST_CYCLES));
    io_wr(KBD_DATA_PORT, 2'b10, 1'b0, 8'h00);
    io_wr(KBD_CMD_PORT, 2'b10, 1'b0, 8'h00);
    io_wr(16'h0061, 2'b10, 1'b1, 8'h00);
    kbd_rd(KBD_DATA_PORT, 1'b0);
    kbd_rd(16'h0065, 1'b1);
    chk("a20 held", 8'h00, 8'(a20));
  endtask
  task automatic t_error();
    @(posedge clk) raise <= 1'b1;
    @(posedge clk) raise <= 1'b0;
    wt(6);
    chk("interrupt", 8'h01, 8'(cpu_interrupt_request));
    io_wr(NPX_CLR_PORT, 2'b00, 1'b1, 8'h00);
    chk("ignore set", 8'h00, 8'(ign_n));
    chk("interrupt cleared", 8'h00, 8'(cpu_interrupt_request));
    wt(40);
    chk("ignore released", 8'h01, 8'(ign_n));
  endtask
  task automatic t_bios_aux();
    @(posedge clk);
    la <= BIOS_LA_MATCH;
    bale <= 1'b1;
    abf <= 1'b1;
    wt(6);
    chk("latch enable", 8'h00, 8'(sale_n));
    chk("boot select", 8'h00, 8'(bios_n));
    chk("aux off", 8'h00, 8'(aux));
    @(posedge clk);
    bale <= 1'b0;
    cfg <= 1'b1;
    wt(2);
    la <= 7'h00;
    wt(6);
    chk("latch enable rise", 8'h01, 8'(sale_n));
    chk("boot select held", 8'h00, 8'(bios_n));
    chk("aux on", 8'h01, 8'(aux));
    @(posedge clk) ref_n <= 1'b0;
    wt(6);
    chk("boot select refresh", 8'h01, 8'(bios_n));
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    wt(6);
    t_reset();
    wt(5);
    @(posedge clk) srst <= 1'b0;
    wt(6);
    t_buffers();
    t_port92();
    t_midrst();
    t_error();
    t_bios_aux();
    end_of_test();
  end
endmodule
